//--- rx_config_pkg.sv
// package of offsets, field positions, reset values and timing for the receiver config registers
`default_nettype none
package rx_config_pkg;
  // register offsets on the register port
  localparam logic [7:0] OFS_PCLK_SRC = 8'h2e;
  localparam logic [7:0] OFS_DUAL_RX = 8'h34;
  localparam logic [7:0] OFS_AEQ_CTL = 8'h35;
  localparam logic [7:0] OFS_STRAP = 8'h37;
  localparam logic [7:0] OFS_DIVSEL = 8'h3a;
  localparam logic [7:0] OFS_FLOOR = 8'h45;
  // reset values
  localparam logic [7:0] RST_PCLK_SRC = 8'h00;
  localparam logic [7:0] RST_DUAL_RX = 8'h01;
  localparam logic [7:0] RST_AEQ_CTL = 8'h00;
  localparam logic [7:0] RST_DIVSEL = 8'h00;
  localparam logic [7:0] RST_FLOOR = 8'h88;
  // writable bit masks; bits outside read back fixed
  localparam logic [7:0] WMASK_DUAL_RX = 8'h7f;
  localparam logic [7:0] WMASK_DIVSEL = 8'hf7;
  // field positions
  localparam int EXT_PCLK_BIT = 7;
  localparam int LOCK_MODE_BIT = 6;
  localparam int RAW_BC_BIT = 5;
  localparam int INPUT_MODE_LSB = 3;
  localparam int PORT_ONE_SEL_BIT = 1;
  localparam int PORT_ZERO_SEL_BIT = 0;
  localparam int EQ_RESTART_BIT = 6;
  localparam int FLOOR_OVR_BIT = 5;
  localparam int FLOOR_APPLY_BIT = 4;
  localparam int FLOOR_VAL_LSB = 0;
  localparam int MDIV_OVR_BIT = 7;
  localparam int MDIV_LSB = 4;
  localparam int MSEL_OVR_BIT = 2;
  localparam int MSEL_LSB = 0;
  // link input modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_PRIMARY = 2'h2;
  localparam logic [1:0] MODE_SECONDARY = 2'h3;
  // strap settling time
  localparam int CLK_PERIOD_NS = 4;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strap decoder states
  typedef enum logic [0:0] {ST_SETTLE = 1'b0, ST_LATCHED = 1'b1} strap_state_type;
endpackage
`default_nettype wire

//--- strap_decoder.sv
// latches one mode-strap pin decode after a settling delay and flags completion
`default_nettype none
module strap_decoder
  import rx_config_pkg::*;
#(
  parameter int SETTLE_CYCLES = rx_config_pkg::STRAP_SETTLE_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] strap_level,
  output logic [2:0] decode_r,
  output logic done_r
);
  // elaboration check: the settle count must lie in 1 to 4096 cycles; the 13-bit counter could reach 8191
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4096)
  begin
    $error("strap_decoder: SETTLE_CYCLES out of range");
  end

  strap_state_type state_r;
  logic [12:0] cnt_r;
  wire settle_end = (cnt_r == 13'(SETTLE_CYCLES - 1));

  // wait for the strap voltage to settle, then capture it once until the next reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= ST_SETTLE;
      cnt_r <= 13'h0000;
      decode_r <= 3'h0;
      done_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_SETTLE:
        begin
          cnt_r <= cnt_r + 13'h0001;
          if (settle_end)
          begin
            state_r <= ST_LATCHED;
            decode_r <= strap_level;
            done_r <= 1'b1;
          end
        end
        default:
        begin
          state_r <= ST_LATCHED;
        end
      endcase
    end
  end

  // the done flag comes with the freshly captured value
  a_strap_capture: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(done_r) |-> decode_r == $past(strap_level))
    else $error("strap decode not latched with done");
  // once latched the decode never changes
  a_strap_stable: assert property (@(posedge clk_sys) disable iff (rst)
    done_r && $past(done_r) |-> $stable(decode_r))
    else $error("strap decode changed after latch");
endmodule
`default_nettype wire

//--- rx_config_regs.sv
// control and status register group of the serial-link deserializer receiver
//
// Contract
// - bit 7 at 2Eh selects test clock pixel clock
// - lock mode 0: lock only with active video
// - lock mode 1: lock whenever linked to serializer
// - raw back-channel passes gpio zero unfiltered
// - input mode field selects receive link configuration
// - port one select: writes port one, reads port one
// - port zero select writes port zero copy
// - both selects set: reads return port one
// - restart written high then low restarts both
// - floor override enable gates floor apply
// - floor apply uses floor value at 45h
// - strap one decode bits 6-4, done bit 7
// - strap zero decode bits 2-0, done bit 3
// - master clock override selects programmed output divide
// - output divide field maps to 32 down to 1
// - input divide override selects programmed input divide
// - input divide field maps to 1,2,4,8
// - video-off flag loaded from serializer
// - floor value 4 bits, reset 8h, start point
`default_nettype none
module rx_config_regs
  import rx_config_pkg::*;
#(
  parameter int STRAP_SETTLE = rx_config_pkg::STRAP_SETTLE_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  output logic reg_rvalid_r,
  input wire logic serializer_linked,
  input wire logic fc_load,
  input wire logic fc_video_off,
  input wire logic fc_dual_link,
  input wire logic gpio_zero_pin,
  input wire logic [2:0] strap_zero_level,
  input wire logic [2:0] strap_one_level,
  input wire logic [5:0] auto_mclk_div_ratio,
  input wire logic [3:0] pll_state_machine_vco_in_ratio,
  output logic pclk_from_test_clock_r,
  output logic rx_lock_r,
  output logic video_disabled_r,
  output logic backchannel_gpio_r,
  output logic dual_link_rx_r,
  output logic secondary_input_r,
  output logic [1:0] equalizer_restart_r,
  output logic [3:0] aeq_start_p0_r,
  output logic [3:0] aeq_start_p1_r,
  output logic [5:0] mclk_div_ratio_r,
  output logic [3:0] vco_in_div_ratio_r
);
  // elaboration check: the strap settle count must lie in 1 to 4096 cycles
  if (STRAP_SETTLE < 1 || STRAP_SETTLE > 4096)
  begin
    $error("rx_config_regs: STRAP_SETTLE out of range");
  end

  // output divide code to ratio
  function automatic logic [5:0] mdiv_ratio(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h01;
    case (code)
      3'h0: r = 6'h20;
      3'h1: r = 6'h10;
      3'h2: r = 6'h08;
      3'h3: r = 6'h04;
      3'h4, 3'h5: r = 6'h02;
      default: r = 6'h01;
    endcase
    return r;
  endfunction

  // input divide code to ratio
  function automatic logic [3:0] msel_ratio(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h1;
    case (code)
      2'h0: r = 4'h1;
      2'h1: r = 4'h2;
      2'h2: r = 4'h4;
      default: r = 4'h8;
    endcase
    return r;
  endfunction

  logic [7:0] pclk_src_r;
  logic [7:0] dual_rx_r;
  logic [7:0] aeq_ctl_r;
  logic [7:0] divsel_r;
  logic [7:0] floor_p0_r;
  logic [7:0] floor_p1_r;
  logic restart_prev_r;
  logic [2:0] bc_hist_r;
  logic [2:0] strap0_dec;
  logic [2:0] strap1_dec;
  logic strap0_done;
  logic strap1_done;

  // address decode
  wire hit_pclk = (reg_addr == OFS_PCLK_SRC);
  wire hit_dual = (reg_addr == OFS_DUAL_RX);
  wire hit_aeq = (reg_addr == OFS_AEQ_CTL);
  wire hit_strap = (reg_addr == OFS_STRAP);
  wire hit_div = (reg_addr == OFS_DIVSEL);
  wire hit_floor = (reg_addr == OFS_FLOOR);

  // control fields
  wire lock_mode = dual_rx_r[LOCK_MODE_BIT];
  wire raw_bc = dual_rx_r[RAW_BC_BIT];
  wire [1:0] input_mode = dual_rx_r[INPUT_MODE_LSB +: 2];
  wire port_one_select = dual_rx_r[PORT_ONE_SEL_BIT];
  wire port_zero_select = dual_rx_r[PORT_ZERO_SEL_BIT];
  wire restart_bit = aeq_ctl_r[EQ_RESTART_BIT];
  wire floor_ovr = aeq_ctl_r[FLOOR_OVR_BIT];
  wire floor_apply = aeq_ctl_r[FLOOR_APPLY_BIT];

  // per-port floor register: selected copies take the write, a read follows port one first
  // port zero copy
  wire wr_floor_p0 = reg_wr && hit_floor && port_zero_select;
  wire wr_floor_p1 = reg_wr && hit_floor && port_one_select;
  wire [7:0] floor_view = port_one_select ? floor_p1_r : floor_p0_r;

  wire [7:0] strap_view = {strap1_done, strap1_dec, strap0_done, strap0_dec};

  // read mux; unmapped offsets return zero
  wire [7:0] rdata_nxt =
    hit_pclk ? pclk_src_r :
    hit_dual ? dual_rx_r :
    hit_aeq ? aeq_ctl_r :
    hit_strap ? strap_view :
    hit_div ? divsel_r :
    hit_floor ? floor_view : 8'h00;

  wire [7:0] dual_rx_nxt = reg_wdata & WMASK_DUAL_RX;
  wire [7:0] divsel_nxt = reg_wdata & WMASK_DIVSEL;

  // register writes; the strap register has no write path at all
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pclk_src_r <= RST_PCLK_SRC;
      dual_rx_r <= RST_DUAL_RX;
      aeq_ctl_r <= RST_AEQ_CTL;
      divsel_r <= RST_DIVSEL;
    end
    else if (reg_wr)
    begin
      if (hit_pclk)
        pclk_src_r <= reg_wdata;
      else if (hit_dual)
        dual_rx_r <= dual_rx_nxt;
      else if (hit_aeq)
        aeq_ctl_r <= reg_wdata;
      else if (hit_div)
        divsel_r <= divsel_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      floor_p0_r <= RST_FLOOR;
      floor_p1_r <= RST_FLOOR;
    end
    else
    begin
      if (wr_floor_p0)
        floor_p0_r <= reg_wdata;
      if (wr_floor_p1)
        floor_p1_r <= reg_wdata;
    end
  end

  // read data lands one cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
        reg_rdata_r <= rdata_nxt;
    end
  end

  // strap decoders, one per mode pin
  strap_decoder #(
    .SETTLE_CYCLES(STRAP_SETTLE)
  ) u_strap_zero (
    .clk_sys(clk_sys),
    .rst(rst),
    .strap_level(strap_zero_level),
    .decode_r(strap0_dec),
    .done_r(strap0_done)
  );

  strap_decoder #(
    .SETTLE_CYCLES(STRAP_SETTLE)
  ) u_strap_one (
    .clk_sys(clk_sys),
    .rst(rst),
    .strap_level(strap_one_level),
    .decode_r(strap1_dec),
    .done_r(strap1_done)
  );

  wire video_off_nxt = fc_load ? fc_video_off : video_disabled_r;
  wire lock_nxt = serializer_linked && (lock_mode || !video_off_nxt);

  // filtered back-channel is a 3-sample majority; raw mode skips it entirely
  wire bc_major = (bc_hist_r[0] & bc_hist_r[1]) | (bc_hist_r[1] & bc_hist_r[2])
                | (bc_hist_r[0] & bc_hist_r[2]);
  wire bc_nxt = raw_bc ? gpio_zero_pin : bc_major;

  wire dual_nxt = (input_mode == MODE_DUAL) || ((input_mode == MODE_AUTO) && fc_dual_link);
  wire sec_nxt = (input_mode == MODE_SECONDARY);

  wire restart_pulse = restart_bit && !restart_prev_r;

  wire floor_en = floor_ovr && floor_apply;
  wire [3:0] start_p0_nxt = floor_en ? floor_p0_r[FLOOR_VAL_LSB +: 4] : 4'h0;
  wire [3:0] start_p1_nxt = floor_en ? floor_p1_r[FLOOR_VAL_LSB +: 4] : 4'h0;

  wire [5:0] mdiv_nxt = divsel_r[MDIV_OVR_BIT] ? mdiv_ratio(divsel_r[MDIV_LSB +: 3])
                                                : auto_mclk_div_ratio;
  wire [3:0] msel_nxt = divsel_r[MSEL_OVR_BIT] ? msel_ratio(divsel_r[MSEL_LSB +: 2])
                                                : pll_state_machine_vco_in_ratio;

  // link-facing outputs, all registered
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pclk_from_test_clock_r <= 1'b0;
      video_disabled_r <= 1'b0;
      rx_lock_r <= 1'b0;
      bc_hist_r <= 3'h0;
      backchannel_gpio_r <= 1'b0;
      dual_link_rx_r <= 1'b0;
      secondary_input_r <= 1'b0;
    end
    else
    begin
      pclk_from_test_clock_r <= pclk_src_r[EXT_PCLK_BIT];
      video_disabled_r <= video_off_nxt;
      rx_lock_r <= lock_nxt;
      bc_hist_r <= {bc_hist_r[1:0], gpio_zero_pin};
      backchannel_gpio_r <= bc_nxt;
      dual_link_rx_r <= dual_nxt;
      secondary_input_r <= sec_nxt;
    end
  end

  // equalizer and clock divider outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      restart_prev_r <= 1'b0;
      equalizer_restart_r <= 2'h0;
      aeq_start_p0_r <= 4'h0;
      aeq_start_p1_r <= 4'h0;
      mclk_div_ratio_r <= 6'h20;
      vco_in_div_ratio_r <= 4'h1;
    end
    else
    begin
      restart_prev_r <= restart_bit;
      equalizer_restart_r <= {restart_pulse, restart_pulse};
      aeq_start_p0_r <= start_p0_nxt;
      aeq_start_p1_r <= start_p1_nxt;
      mclk_div_ratio_r <= mdiv_nxt;
      vco_in_div_ratio_r <= msel_nxt;
    end
  end

  // lock drops one cycle after video goes off in mode 0
  a_lock_video_off: assert property (@(posedge clk_sys) disable iff (rst)
    !lock_mode && fc_load && fc_video_off |=> !rx_lock_r)
    else $error("lock held with video off in mode 0");
  // mode 1 locks on link alone
  a_lock_link_only: assert property (@(posedge clk_sys) disable iff (rst)
    lock_mode && serializer_linked |=> rx_lock_r)
    else $error("no lock while linked in mode 1");
  // raw mode mirrors the pin one cycle later
  a_raw_backchannel: assert property (@(posedge clk_sys) disable iff (rst)
    raw_bc |=> backchannel_gpio_r == $past(gpio_zero_pin))
    else $error("raw back-channel not passed through");
  // write to pixel clock select shows two cycles later
  a_pclk_select: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && hit_pclk |=> ##1 pclk_from_test_clock_r == $past(reg_wdata[EXT_PCLK_BIT], 2))
    else $error("pixel clock select not applied");
  // forced secondary input never runs dual
  a_input_secondary: assert property (@(posedge clk_sys) disable iff (rst)
    input_mode == MODE_SECONDARY |=> secondary_input_r && !dual_link_rx_r)
    else $error("secondary input mode not applied");
  // restart pulses both ports exactly once per rising edge
  a_restart_once: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(restart_bit) |=> equalizer_restart_r == 2'h3 ##1 equalizer_restart_r == 2'h0)
    else $error("restart pulse wrong");
  // without override the start point stays zero
  a_floor_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !floor_ovr && !$past(floor_ovr) |-> aeq_start_p0_r == 4'h0 && aeq_start_p1_r == 4'h0)
    else $error("floor applied without override");
  // read with both selects returns port one copy
  a_port_one_read: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && hit_floor && port_one_select |=> reg_rdata_r == $past(floor_p1_r))
    else $error("port one read mismatch");
  // port zero copy untouched by writes with port zero deselected
  a_port_zero_hold: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && hit_floor && !port_zero_select |=> $stable(floor_p0_r))
    else $error("port zero copy written while deselected");
  // override programs output divide code 000 to 32
  a_mdiv_override: assert property (@(posedge clk_sys) disable iff (rst)
    divsel_r[MDIV_OVR_BIT] && divsel_r[MDIV_LSB +: 3] == 3'h0 |=> mclk_div_ratio_r == 6'h20)
    else $error("output divide override wrong");
  // without input override the state machine ratio passes
  a_msel_auto: assert property (@(posedge clk_sys) disable iff (rst)
    !divsel_r[MSEL_OVR_BIT] |=> vco_in_div_ratio_r == $past(pll_state_machine_vco_in_ratio))
    else $error("input divide source wrong");
  // read-only bits stay zero after any write
  a_ro_bits: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr |=> dual_rx_r[7] == 1'b0 && divsel_r[3] == 1'b0)
    else $error("read-only bit written");
endmodule
`default_nettype wire

//--- serializer_model.sv
// behavioural remote serializer driving the forward-channel status lines
`default_nettype none
module serializer_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic link_cmd,
  input wire logic send_cmd,
  input wire logic video_off_cmd,
  input wire logic dual_cmd,
  output logic serializer_linked,
  output logic fc_load,
  output logic fc_video_off,
  output logic fc_dual_link
);
  timeunit 1ns;
  timeprecision 1ps;

  // one config frame per send; the flag line toggles between loads so
  // a receiver that samples it without the strobe shows up at once
  // flag valid with strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      serializer_linked <= 1'b0;
      fc_load <= 1'b0;
      fc_video_off <= 1'b0;
      fc_dual_link <= 1'b0;
    end
    else
    begin
      serializer_linked <= link_cmd;
      fc_load <= send_cmd;
      fc_video_off <= send_cmd ? video_off_cmd : ~fc_video_off;
      if (send_cmd)
        fc_dual_link <= dual_cmd;
    end
  end
endmodule
`default_nettype wire

//--- rx_config_regs_test.sv
// self-checking bench for the receiver config register group
`default_nettype none
module rx_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_config_pkg::*;

  // short strap settle keeps the run brief
  localparam int SETTLE = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic gpio_zero_pin = 1'b0;
  logic link_cmd = 1'b0;
  logic send_cmd = 1'b0;
  logic vo_cmd = 1'b0;
  logic dual_cmd = 1'b0;
  logic [2:0] s0_lvl = 3'h5;
  logic [2:0] s1_lvl = 3'h2;
  logic [5:0] auto_div = 6'h0c;
  logic [3:0] pll_div = 4'h4;
  logic [7:0] reg_rdata_r;
  logic reg_rvalid_r, serializer_linked, fc_load, fc_video_off, fc_dual_link;
  logic pclk_from_test_clock_r, rx_lock_r, video_disabled_r, backchannel_gpio_r;
  logic dual_link_rx_r, secondary_input_r;
  logic [1:0] equalizer_restart_r;
  logic [3:0] aeq_start_p0_r, aeq_start_p1_r, vco_in_div_ratio_r;
  logic [5:0] mclk_div_ratio_r;
  int n_fail = 0;
  int compares = 0;

  always #2 clk_sys = ~clk_sys;

  serializer_model i_serializer (.clk_sys(clk_sys), .rst(rst), .link_cmd(link_cmd),
    .send_cmd(send_cmd), .video_off_cmd(vo_cmd), .dual_cmd(dual_cmd),
    .serializer_linked(serializer_linked), .fc_load(fc_load),
    .fc_video_off(fc_video_off), .fc_dual_link(fc_dual_link));

  rx_config_regs #(.STRAP_SETTLE(SETTLE)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .serializer_linked(serializer_linked), .fc_load(fc_load),
    .fc_video_off(fc_video_off), .fc_dual_link(fc_dual_link),
    .gpio_zero_pin(gpio_zero_pin), .strap_zero_level(s0_lvl), .strap_one_level(s1_lvl),
    .auto_mclk_div_ratio(auto_div), .pll_state_machine_vco_in_ratio(pll_div),
    .pclk_from_test_clock_r(pclk_from_test_clock_r), .rx_lock_r(rx_lock_r),
    .video_disabled_r(video_disabled_r), .backchannel_gpio_r(backchannel_gpio_r),
    .dual_link_rx_r(dual_link_rx_r), .secondary_input_r(secondary_input_r),
    .equalizer_restart_r(equalizer_restart_r), .aeq_start_p0_r(aeq_start_p0_r),
    .aeq_start_p1_r(aeq_start_p1_r), .mclk_div_ratio_r(mclk_div_ratio_r),
    .vco_in_div_ratio_r(vco_in_div_ratio_r));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write strobe; strobe drops at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data and valid land one cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h0, reg_rvalid_r});
    chk($sformatf("read %h", a), exp, reg_rdata_r);
  endtask

  // status outputs settle within three cycles of their causes
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic send(input logic vo, input logic dl);
    @(posedge clk_sys);
    send_cmd <= 1'b1;
    vo_cmd <= vo;
    dual_cmd <= dl;
    @(posedge clk_sys);
    send_cmd <= 1'b0;
    settle;
  endtask

  // gpio pulse of w cycles, then count cycles the back-channel bit is high
  task automatic pulse(input int w, output int n);
    @(posedge clk_sys);
    gpio_zero_pin <= 1'b1;
    repeat (w) @(posedge clk_sys);
    gpio_zero_pin <= 1'b0;
    n = 0;
    repeat (8)
    begin
      #1;
      n += int'(backchannel_gpio_r === 1'b1);
      @(posedge clk_sys);
    end
  endtask

  task automatic t_reset;
    rd_chk(OFS_PCLK_SRC, 8'h00);
    rd_chk(OFS_DUAL_RX, 8'h01);
    rd_chk(OFS_AEQ_CTL, 8'h00);
    rd_chk(OFS_DIVSEL, 8'h00);
    rd_chk(OFS_FLOOR, 8'h88);
    rd_chk(8'h50, 8'h00);
    chk("mclk auto", {2'b0, auto_div}, {2'b0, mclk_div_ratio_r});
    chk("vco auto", {4'b0, pll_div}, {4'b0, vco_in_div_ratio_r});
  endtask

  task automatic t_misc;
    wr(OFS_STRAP, 8'h52);
    rd_chk(OFS_STRAP, 8'had);
    wr(OFS_PCLK_SRC, 8'h80);
    settle;
    chk("pclk sel", 8'h01, {7'h0, pclk_from_test_clock_r});
    wr(OFS_PCLK_SRC, 8'h00);
    settle;
    chk("pclk rec", 8'h00, {7'h0, pclk_from_test_clock_r});
    wr(OFS_DUAL_RX, 8'h81);
    rd_chk(OFS_DUAL_RX, 8'h01);
  endtask

  task automatic t_lock;
    @(posedge clk_sys);
    link_cmd <= 1'b1;
    send(1'b1, 1'b0);
    chk("lock vid off", 8'h00, {7'h0, rx_lock_r});
    chk("vid flag", 8'h01, {7'h0, video_disabled_r});
    send(1'b0, 1'b0);
    chk("lock vid on", 8'h01, {7'h0, rx_lock_r});
    send(1'b1, 1'b0);
    wr(OFS_DUAL_RX, 8'h41);
    settle;
    chk("lock ctl only", 8'h01, {7'h0, rx_lock_r});
    @(posedge clk_sys);
    link_cmd <= 1'b0;
    settle;
    chk("lock unlinked", 8'h00, {7'h0, rx_lock_r});
    wr(OFS_DUAL_RX, 8'h01);
  endtask

  task automatic t_bc;
    int n;
    pulse(1, n);
    chk("bc glitch", 8'h00, 8'(n));
    pulse(3, n);
    chk("bc filtered", 8'h03, 8'(n));
    wr(OFS_DUAL_RX, 8'h21);
    settle;
    pulse(1, n);
    chk("bc raw", 8'h01, 8'(n));
    wr(OFS_DUAL_RX, 8'h01);
  endtask

  task automatic t_mode;
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_DUAL_RX, {3'b000, m[1:0], 3'b001});
      settle;
      chk("dual", {7'h0, m == 1}, {7'h0, dual_link_rx_r});
      chk("secondary", {7'h0, m == 3}, {7'h0, secondary_input_r});
    end
    wr(OFS_DUAL_RX, 8'h01);
    send(1'b0, 1'b1);
    chk("auto dual", 8'h01, {7'h0, dual_link_rx_r});
  endtask

  task automatic t_port;
    wr(OFS_FLOOR, 8'h03);
    wr(OFS_DUAL_RX, 8'h02);
    wr(OFS_FLOOR, 8'h05);
    rd_chk(OFS_FLOOR, 8'h05);
    wr(OFS_DUAL_RX, 8'h03);
    rd_chk(OFS_FLOOR, 8'h05);
    wr(OFS_DUAL_RX, 8'h01);
    rd_chk(OFS_FLOOR, 8'h03);
    wr(OFS_AEQ_CTL, 8'h30);
    settle;
    chk("start p0", 8'h03, {4'h0, aeq_start_p0_r});
    chk("start p1", 8'h05, {4'h0, aeq_start_p1_r});
    wr(OFS_AEQ_CTL, 8'h10);
    settle;
    chk("no override", 8'h00, {4'h0, aeq_start_p0_r});
    wr(OFS_DUAL_RX, 8'h03);
    wr(OFS_FLOOR, 8'h09);
    wr(OFS_AEQ_CTL, 8'h30);
    settle;
    chk("both p0", 8'h09, {4'h0, aeq_start_p0_r});
    chk("both p1", 8'h09, {4'h0, aeq_start_p1_r});
  endtask

  task automatic t_restart;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_AEQ_CTL, k == 0 ? 8'h70 : 8'h30);
      n = 0;
      repeat (6)
      begin
        @(posedge clk_sys);
        #1;
        n += int'(equalizer_restart_r === 2'b11);
      end
      chk("restart", 8'(1 - k), 8'(n));
    end
  endtask

  task automatic t_div;
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_DIVSEL, {1'b1, i[2:0], 2'b11, i[1:0]});
      settle;
      chk("mdiv", i < 4 ? 8'd32 >> i : (i < 6 ? 8'd2 : 8'd1), {2'b0, mclk_div_ratio_r});
      chk("msel", 8'd1 << i[1:0], {4'b0, vco_in_div_ratio_r});
    end
    rd_chk(OFS_DIVSEL, 8'hf7);
    wr(OFS_DIVSEL, 8'h73);
    settle;
    chk("mdiv auto", {2'b0, auto_div}, {2'b0, mclk_div_ratio_r});
    chk("msel pll", {4'b0, pll_div}, {4'b0, vco_in_div_ratio_r});
  endtask

  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reset for two cycles, then every scenario in turn
  initial
  begin
    @(posedge clk_sys);
    #1;
    // divide outputs hold their reset ratios only while reset stands
    chk("mclk rst", 8'd32, {2'b0, mclk_div_ratio_r});
    chk("vco rst", 8'd1, {4'b0, vco_in_div_ratio_r});
    @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_misc;
    t_lock;
    t_bc;
    t_mode;
    t_port;
    t_restart;
    t_div;
    final_report;
  end
endmodule
`default_nettype wire
